/* File: logic/tdw_chan_regs.sv */
// Purpose: per-channel head, completion and teardown state
// Assumes: writes come from the plain register port
// Notes:   one generate loop holds every channel
`timescale 1ns/1ns
module tdw_chan_regs
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [tdw_pkg::NCH-1:0] hdp_we,
   input  wire logic [tdw_pkg::NCH-1:0] cp_we,
   input  wire logic [tdw_pkg::NCH-1:0] td_we,
   input  wire logic [31:0]          wdata,
   input  wire logic [tdw_pkg::NCH-1:0] take,
   input  wire logic [tdw_pkg::NCH-1:0] done,
   input  wire logic [tdw_pkg::NCH-1:0] td_ack,
   input  wire logic [31:0]          eng_ptr,
   input  wire logic [31:0]          eng_cp,
   output logic [tdw_pkg::NCH-1:0][31:0] hdp_q,
   output logic [tdw_pkg::NCH-1:0][31:0] cp_q,
   output logic [tdw_pkg::NCH-1:0][31:0] ack_q,
   output logic [tdw_pkg::NCH-1:0]   act_q,
   output logic [tdw_pkg::NCH-1:0]   td_q
);
   genvar g;
   generate
      for (g = 0; g < tdw_pkg::NCH; g++)
      begin : g_ch
         // head pointer: software load, engine advances it while walking
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               hdp_q[g] <= tdw_pkg::PTR_RESET;
               act_q[g] <= 1'b0;
            end
            else if (hdp_we[g])
            begin
               hdp_q[g] <= wdata;
               act_q[g] <= (wdata != 32'h0);
            end
            else if (take[g])
            begin
               hdp_q[g] <= eng_ptr;
               act_q[g] <= (eng_ptr != 32'h0);
            end
         end
         // completion pointer from engine, acknowledge value from software
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               cp_q[g]  <= tdw_pkg::PTR_RESET;
               ack_q[g] <= tdw_pkg::PTR_RESET;
            end
            else
            begin
               if (done[g])
                  cp_q[g] <= eng_cp;
               if (cp_we[g])
                  ack_q[g] <= wdata;
            end
         end
         // teardown request, set wins over the engine's acknowledge
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
               td_q[g] <= 1'b0;
            else if (td_we[g])
               td_q[g] <= 1'b1;
            else if (td_ack[g])
               td_q[g] <= 1'b0;
         end
      end
   endgenerate
endmodule : tdw_chan_regs

/* File: logic/tdw_pkg.sv */
// Purpose: constants and types for the transmit descriptor chain walker
// Assumes: 32-bit byte-addressed memory port, eight transmit channels
// Notes:   flag positions sit in the flags/packet-length word
//
// Contract
// - descriptor is four aligned 32-bit words
// - completion pointer reads last processed descriptor (engine loads the first descriptor of the last packet)
// - pass-crc flag suppresses generated frame check
// - next word zero ends the queue
// - engine never writes words zero to two
// - patch before fetch is followed
// - patch after fetch halts the channel
// - buffer pointer is any byte address
// - skip offset bytes before valid data
// - offset applies on first fragment only
// - buffer length counts valid bytes only
// - packet length equals sum of fragments
// - engine never alters start or end flags
// - clear held flag after whole packet
// - end flag plus zero next sets end-of-queue
// - teardown flags aborted packet's first descriptor
// - teardown flags one packet then stops
package tdw_pkg;
   localparam int NCH = 8;
   localparam int CHW = 3;
   // register offsets on the plain port, one word each, channel in bits 4:2
   localparam logic [7:0] HDP_BASE = 8'h00;   // tx_head_pointer_reg n at 0x00 + 4n
   localparam logic [7:0] CP_BASE  = 8'h20;   // tx_completion_pointer_reg n at 0x20 + 4n
   localparam logic [7:0] TD_REG   = 8'h40;   // write channel number to tear it down
   localparam logic [7:0] ST_REG   = 8'h44;   // active channel bits, read only
   localparam logic [7:0] IRQ_REG  = 8'h48;   // completion pending bits, read only
   // descriptor word byte offsets
   localparam logic [31:0] W_NEXT = 32'h0000_0000;
   localparam logic [31:0] W_BUF  = 32'h0000_0004;
   localparam logic [31:0] W_OFL  = 32'h0000_0008;
   localparam logic [31:0] W_FLG  = 32'h0000_000c;
   localparam int F_START = 31;
   localparam int F_END   = 30;
   localparam int F_OWN   = 29;
   localparam int F_QEND  = 28;
   localparam int F_TDC  = 27;
   localparam int F_PCRC = 26;
   localparam logic [31:0] PTR_RESET = 32'h0000_0000;

   typedef struct packed {
      logic        first;   // first fragment of a packet
      logic [31:0] addr;   // byte address of first data byte
      logic [15:0] len;    // valid bytes in this fragment
      logic        last;    // last fragment of a packet
      logic        gen_crc;
      logic [2:0]  chan;
   } tdw_frag_s;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } tdw_mem_req_s;
endpackage : tdw_pkg

/* File: logic/tdw_walker.sv */
// Purpose: walks transmit descriptor chains and hands fragments to the mac
// Assumes: memory port answers a read with mem_rvalid, a write with mem_wdone
// Notes:   one channel served at a time, lowest active channel first
`timescale 1ns/1ns
module tdw_walker
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata,
   output tdw_pkg::tdw_mem_req_s    mem_req,
   input  wire logic                mem_rvalid,
   input  wire logic [31:0]         mem_rdata,
   input  wire logic                mem_wdone,
   output tdw_pkg::tdw_frag_s       frag,
   output logic                     frag_valid,
   input  wire logic                frag_ready,
   output logic [tdw_pkg::NCH-1:0]  irq_raw
);
   typedef enum logic [3:0] {
      S_IDLE, S_RD_FLG, S_RD_OFL, S_RD_BUF, S_RD_NXT, S_SEND,
      S_WR_QEND, S_WR_FIRST, S_TD_WR
   } tdw_state_e;

   tdw_state_e state_q;
   logic [tdw_pkg::CHW-1:0] ch_q;
   logic [31:0] desc_q;      // descriptor being walked
   logic [31:0] first_q;     // first-fragment descriptor of the packet
   logic [31:0] first_flg_q; // flags word of the first fragment
   logic [31:0] flg_q;
   logic [31:0] ofl_q;
   logic [31:0] buf_q;
   logic [31:0] nxt_q;
   logic [tdw_pkg::NCH-1:0][31:0] hdp;
   logic [tdw_pkg::NCH-1:0][31:0] cpv;
   logic [tdw_pkg::NCH-1:0][31:0] ackv;
   logic [tdw_pkg::NCH-1:0] act;
   logic [tdw_pkg::NCH-1:0] tdq;
   logic [tdw_pkg::NCH-1:0] take;
   logic [tdw_pkg::NCH-1:0] done;
   logic [tdw_pkg::NCH-1:0] td_ack;
   logic [tdw_pkg::NCH-1:0] irq_d;
   logic [31:0] eng_ptr;
   logic [31:0] rdata_d;

   // register decode, channel index from address bits 4:2
   wire [2:0] rch    = reg_addr[4:2];
   wire       is_hdp = (reg_addr[7:5] == tdw_pkg::HDP_BASE[7:5]);
   wire       is_cp  = (reg_addr[7:5] == tdw_pkg::CP_BASE[7:5]);
   wire       is_td  = (reg_addr == tdw_pkg::TD_REG);
   wire [tdw_pkg::NCH-1:0] onehot = 8'h01 << rch;
   wire [tdw_pkg::NCH-1:0] td_sel = 8'h01 << reg_wdata[2:0];
   wire [tdw_pkg::NCH-1:0] hdp_we = (reg_wr && is_hdp) ? onehot : 8'h00;
   wire [tdw_pkg::NCH-1:0] cp_we  = (reg_wr && is_cp) ? onehot : 8'h00;
   wire [tdw_pkg::NCH-1:0] td_we  = (reg_wr && is_td) ? td_sel : 8'h00;

   tdw_chan_regs u_regs
   (
      .core_clk (core_clk),
      .rst      (rst),
      .hdp_we   (hdp_we),
      .cp_we    (cp_we),
      .td_we    (td_we),
      .wdata    (reg_wdata),
      .take     (take),
      .done     (done),
      .td_ack   (td_ack),
      .eng_ptr  (eng_ptr),
      .eng_cp   (first_q),
      .hdp_q    (hdp),
      .cp_q     (cpv),
      .ack_q    (ackv),
      .act_q    (act),
      .td_q     (tdq)
   );

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_d = 32'h0;
      if (is_hdp)
         rdata_d = hdp[rch];
      else if (is_cp)
         rdata_d = cpv[rch];
      else if (reg_addr == tdw_pkg::ST_REG)
         rdata_d = {24'h0, act};
      else if (reg_addr == tdw_pkg::IRQ_REG)
         rdata_d = {24'h0, irq_raw};
   end

   always_comb
   begin
      for (int i = 0; i < tdw_pkg::NCH; i++)
         irq_d[i] = (cpv[i] != ackv[i]);
   end

   // channel pick: lowest active channel; teardowns of idle channels are only acknowledged
   logic [tdw_pkg::CHW-1:0] pick;
   logic                    pick_ok;
   always_comb
   begin
      pick    = 3'h0;
      pick_ok = 1'b0;
      for (int i = tdw_pkg::NCH - 1; i >= 0; i--)
         if (act[i])
         begin
            pick    = i[2:0];
            pick_ok = 1'b1;
         end
   end

   // fields of the fetched words
   wire        f_first = flg_q[tdw_pkg::F_START];
   wire        f_last  = flg_q[tdw_pkg::F_END];
   wire [15:0] f_off   = ofl_q[31:16];
   wire [15:0] f_blen  = ofl_q[15:0];
   wire        fire    = frag_valid && frag_ready;
   wire        nxt_nul = (nxt_q == 32'h0);
   wire        td_now  = tdq[ch_q];

   wire [31:0] skip    = f_first ? {16'h0, f_off} : 32'h0;
   wire [31:0] dat_adr = buf_q + skip;

   // pointer handed back to the channel registers when the walk moves on
   assign eng_ptr = (state_q == S_TD_WR) ? 32'h0 : nxt_q;

   always_comb
   begin
      take   = '0;
      done   = '0;
      td_ack = '0;
      // nothing is left to abort on a halted channel, so its request is dropped
      for (int i = 0; i < tdw_pkg::NCH; i++)
         td_ack[i] = tdq[i] && !act[i];
      if (state_q == S_SEND && fire && !f_last)
         take[ch_q] = 1'b1;
      if (state_q == S_WR_FIRST && mem_wdone)
      begin
         take[ch_q] = 1'b1;
         done[ch_q] = 1'b1;
      end
      if (state_q == S_TD_WR && mem_wdone)
      begin
         take[ch_q]   = 1'b1;
         done[ch_q]   = 1'b1;
         td_ack[ch_q] = 1'b1;
      end
   end

   // walk sequencer
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q    <= S_IDLE;
         ch_q       <= 3'h0;
         desc_q     <= 32'h0;
         first_q    <= 32'h0;
         first_flg_q <= 32'h0;
         flg_q      <= 32'h0;
         ofl_q      <= 32'h0;
         buf_q      <= 32'h0;
         nxt_q      <= 32'h0;
         mem_req    <= '0;
         frag       <= '0;
         frag_valid <= 1'b0;
      end
      else
      begin
         mem_req.rd <= 1'b0;
         mem_req.wr <= 1'b0;
         case (state_q)
            S_IDLE:
            begin
               if (pick_ok)
               begin
                  ch_q        <= pick;
                  desc_q      <= {hdp[pick][31:2], 2'b00};
                  first_q     <= {hdp[pick][31:2], 2'b00};
                  mem_req.rd   <= 1'b1;
                  mem_req.addr <= {hdp[pick][31:2], 2'b00} + tdw_pkg::W_FLG;
                  state_q      <= S_RD_FLG;
               end
            end
            S_RD_FLG:
            begin
               if (mem_rvalid)
               begin
                  flg_q <= mem_rdata;
                  if (mem_rdata[tdw_pkg::F_START])
                  begin
                     first_q     <= desc_q;
                     first_flg_q <= mem_rdata;
                  end
                  if (td_now && mem_rdata[tdw_pkg::F_START])
                  begin
                     mem_req.wr    <= 1'b1;
                     mem_req.addr  <= desc_q + tdw_pkg::W_FLG;
                     mem_req.wdata <= mem_rdata | (32'h1 << tdw_pkg::F_TDC);
                     state_q       <= S_TD_WR;
                  end
                  else
                  begin
                     mem_req.rd   <= 1'b1;
                     mem_req.addr <= desc_q + tdw_pkg::W_OFL;
                     state_q      <= S_RD_OFL;
                  end
               end
            end
            S_RD_OFL:
            begin
               if (mem_rvalid)
               begin
                  ofl_q        <= mem_rdata;
                  mem_req.rd   <= 1'b1;
                  mem_req.addr <= desc_q + tdw_pkg::W_BUF;
                  state_q      <= S_RD_BUF;
               end
            end
            S_RD_BUF:
            begin
               if (mem_rvalid)
               begin
                  buf_q        <= mem_rdata;
                  mem_req.rd   <= 1'b1;
                  mem_req.addr <= desc_q + tdw_pkg::W_NEXT;
                  state_q      <= S_RD_NXT;
               end
            end
            S_RD_NXT:
            begin
               if (mem_rvalid)
               begin
                  nxt_q        <= {mem_rdata[31:2], 2'b00};
                  frag.first   <= f_first;
                  frag.addr    <= dat_adr;
                  frag.len     <= f_blen;
                  frag.last    <= f_last;
                  frag.gen_crc <= !first_flg_q[tdw_pkg::F_PCRC];
                  frag.chan    <= ch_q;
                  frag_valid   <= 1'b1;
                  state_q      <= S_SEND;
               end
            end
            S_SEND:
            begin
               if (fire)
               begin
                  frag_valid <= 1'b0;
                  if (!f_last && !nxt_nul)
                  begin
                     // stay on this channel so the packet's first descriptor is kept
                     desc_q       <= nxt_q;
                     mem_req.rd   <= 1'b1;
                     mem_req.addr <= nxt_q + tdw_pkg::W_FLG;
                     state_q      <= S_RD_FLG;
                  end
                  // a chain cut inside a packet halts the channel
                  else if (!f_last)
                     state_q <= S_IDLE;
                  else if (nxt_nul)
                  begin
                     mem_req.wr    <= 1'b1;
                     mem_req.addr  <= desc_q + tdw_pkg::W_FLG;
                     mem_req.wdata <= flg_q | (32'h1 << tdw_pkg::F_QEND);
                     state_q       <= S_WR_QEND;
                  end
                  else
                  begin
                     mem_req.wr    <= 1'b1;
                     mem_req.addr  <= first_q + tdw_pkg::W_FLG;
                     mem_req.wdata <= first_flg_q & ~(32'h1 << tdw_pkg::F_OWN);
                     state_q       <= S_WR_FIRST;
                  end
               end
            end
            S_WR_QEND:
            begin
               if (mem_wdone)
               begin
                  // the queue-end descriptor may also be the first fragment
                  mem_req.wr    <= 1'b1;
                  mem_req.addr  <= first_q + tdw_pkg::W_FLG;
                  mem_req.wdata <= (first_q == desc_q)
                                   ? (flg_q | (32'h1 << tdw_pkg::F_QEND)) & ~(32'h1 << tdw_pkg::F_OWN)
                                   : first_flg_q & ~(32'h1 << tdw_pkg::F_OWN);
                  state_q       <= S_WR_FIRST;
               end
            end
            S_WR_FIRST:
            begin
               if (mem_wdone)
                  state_q <= S_IDLE;
            end
            S_TD_WR:
            begin
               if (mem_wdone)
                  state_q <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   // read data one cycle after the strobe, interrupt level registered
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= 32'h0;
         irq_raw   <= '0;
      end
      else
      begin
         reg_rdata <= reg_rd ? rdata_d : 32'h0;
         irq_raw   <= irq_d;
      end
   end
endmodule : tdw_walker

/* File: test/tb_tx_descriptor_chain_walker.sv */
// Purpose: self-checking bench for the descriptor walker
// Assumes: bench plays host software and the mac fragment sink
// Notes:   random sizes, latency and sink stalls from a fixed seed
`timescale 1ns/1ns
module tb_tx_descriptor_chain_walker;
   logic                  core_clk, rst, reg_wr, reg_rd, frag_ready, mem_rvalid, mem_wdone, frag_valid;
   logic [7:0]            reg_addr, irq_raw;
   logic [31:0]           reg_wdata, reg_rdata, mem_rdata, seed, rr, s, base;
   logic [3:0]            lat;
   logic [7:0]            ra [5] = '{8'h00, 8'h20, 8'h44, 8'h48, 8'h4c};
   tdw_pkg::tdw_mem_req_s mem_req;
   tdw_pkg::tdw_frag_s    frag, ef;
   tdw_pkg::tdw_frag_s    exp_q [$];
   int                    bad_count, checked, cyc, bad_wr, np;
   int                    nf [3];

   tdw_walker u_tdw_walker (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mem_req, .mem_rvalid, .mem_rdata, .mem_wdone, .frag, .frag_valid, .frag_ready, .irq_raw);
   tdw_host_mem u_tdw_host_mem (.core_clk, .rst, .mem_req, .lat, .mem_rvalid, .mem_rdata,
      .mem_wdone, .bad_wr);

   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : reg_read

   // software side: build one packet and, if asked, expect its fragments
   task automatic build_pkt(input logic [31:0] a, input int n, input logic [2:0] ch,
                            input logic [31:0] nxt, input bit ex);
      logic [31:0] r, bp, da;
      logic [15:0] len, off, tot;
      logic        pc;
      tdw_pkg::tdw_frag_s f;
      tot = 16'h0;
      r = rnd();
      pc = r[0];
      for (int i = 0; i < n; i++)
      begin
         da = a + 32'(16 * i);
         r = rnd();
         len = 16'(r % 300) + 16'h1;
         // offset at most length minus one, boundary on single packets
         off = (n == 1) ? len - 16'h1 : 16'(rnd() % len);
         bp = rnd();
         tot = tot + len;
         u_tdw_host_mem.mem[da[13:2]] = (i == n - 1) ? nxt : da + 32'h10;
         u_tdw_host_mem.mem[da[13:2] + 1] = bp;
         u_tdw_host_mem.mem[da[13:2] + 2] = {off, len};
         u_tdw_host_mem.mem[da[13:2] + 3] = {i == 0, i == n - 1, i == 0, 2'b00, pc & (i == 0), 26'h0};
         f = '{i == 0, bp + ((i == 0) ? {16'h0, off} : 32'h0), len, i == n - 1, !pc, ch};
         if (ex)
            exp_q.push_back(f);
      end
      // packet length is the fragment sum
      u_tdw_host_mem.mem[a[13:2] + 3][15:0] = tot;
   endtask : build_pkt

   task automatic chk_pkt(input logic [31:0] a, input int n, input logic qend);
      logic [31:0] fs, fe;
      fs = u_tdw_host_mem.mem[a[13:2] + 3];
      fe = u_tdw_host_mem.mem[a[13:2] + 12'(4 * n - 1)];
      check("held flag", fs[tdw_pkg::F_OWN], 0);
      check("start flag", fs[tdw_pkg::F_START], 1);
      check("end flag", fe[tdw_pkg::F_END], 1);
      check("queue end flag", fe[tdw_pkg::F_QEND], qend);
   endtask : chk_pkt

   // poll the active bits until the channel stops and all fragments came
   task automatic wait_idle(input int ch);
      logic [31:0] st;
      int          k;
      k = 0;
      st = 32'hff;
      while ((st[ch] !== 1'b0 || exp_q.size() != 0) && k < 400)
      begin
         reg_read(tdw_pkg::ST_REG, st);
         k++;
      end
      check("channel idle", st[ch], 0);
   endtask : wait_idle

   // sink stalls at random, arriving fragments compared in order
   always @(posedge core_clk)
   begin
      rr = rnd();
      frag_ready <= !rst && rr[1:0] != 2'b00;
      cyc++;
      if (cyc == 50000)
      begin
         bad_count++;
         conclude();
      end
      if (!rst && frag_valid && frag_ready)
      begin
         ef = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
         check("fragment", frag, ef);
      end
   end

   initial
   begin
      seed = 32'h3d91;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      frag_ready = 1'b0;
      lat = 4'h1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      reg_write(8'h4c, 32'hffff_ffff);
      foreach (ra[i])
      begin
         reg_read(ra[i], s);
         check("reset value", s, 0);
      end
      // chained packets on four channels with random shape and latency
      for (int c = 0; c < 4; c++)
      begin
         base = 32'h100 + 32'(c) * 32'h400;
         np = 1 + int'(rnd() % 3);
         lat <= 4'(1 + rnd() % 8);
         for (int p = 0; p < np; p++)
         begin
            nf[p] = 1 + int'(rnd() % 2);
            build_pkt(base + 32'(p * 64), nf[p], 3'(c), (p == np - 1) ? 32'h0 : base + 32'(p * 64 + 64), 1);
         end
         reg_write(8'(4 * c), base);
         wait_idle(c);
         for (int p = 0; p < np; p++)
            chk_pkt(base + 32'(p * 64), nf[p], p == np - 1);
         reg_read(8'h20 + 8'(4 * c), s);
         check("completion pointer", s, base + 32'((np - 1) * 64));
         check("event raised", irq_raw[c], 1);
         reg_write(8'h20 + 8'(4 * c), s);
         repeat (3) @(posedge core_clk);
         check("event acknowledged", irq_raw[c], 0);
      end
      // zero next word patched while the engine is still on flags
      lat <= 4'h8;
      build_pkt(32'h2000, 1, 3'd5, 32'h0, 1);
      build_pkt(32'h2040, 2, 3'd5, 32'h0, 1);
      reg_write(8'h14, 32'h2000);
      u_tdw_host_mem.mem[12'h800] = 32'h2040;
      wait_idle(5);
      chk_pkt(32'h2000, 1, 0);
      chk_pkt(32'h2040, 2, 1);
      // patch after the zero was fetched: channel stays halted
      build_pkt(32'h2400, 1, 3'd6, 32'h0, 1);
      reg_write(8'h18, 32'h2400);
      wait_idle(6);
      build_pkt(32'h2440, 1, 3'd6, 32'h0, 1);
      u_tdw_host_mem.mem[12'h900] = 32'h2440;
      repeat (60) @(posedge core_clk);
      check("halted channel", exp_q.size(), 1);
      reg_write(8'h18, 32'h2440);
      wait_idle(6);
      chk_pkt(32'h2400, 1, 1);
      chk_pkt(32'h2440, 1, 1);
      // teardown right after start: first packet flagged, second untouched
      build_pkt(32'h3000, 1, 3'd7, 32'h3040, 0);
      build_pkt(32'h3040, 1, 3'd7, 32'h0, 0);
      reg_write(8'h1c, 32'h3000);
      reg_write(tdw_pkg::TD_REG, 32'h7);
      wait_idle(7);
      check("aborted flag", u_tdw_host_mem.mem[12'hc03][tdw_pkg::F_TDC], 1);
      check("next packet", u_tdw_host_mem.mem[12'hc13][tdw_pkg::F_OWN:tdw_pkg::F_TDC], 3'b100);
      reg_read(8'h3c, s);
      check("aborted pointer", s, 32'h3000);
      check("stray writes", bad_wr, 0);
      conclude();
   end
endmodule : tb_tx_descriptor_chain_walker

bind tdw_walker tdw_walker_props u_tdw_walker_props (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .mem_req, .mem_rvalid, .mem_wdone, .frag, .frag_valid, .frag_ready, .irq_raw);

/* File: test/tdw_host_mem.sv */
// Purpose: shared memory that holds the software descriptor lists
// Assumes: descriptors sit on 16-byte boundaries inside 16 KB
// Notes:   read latency comes from the bench, writes answer next cycle
`timescale 1ns/1ns
module tdw_host_mem
(
   input wire logic             core_clk,
   input wire logic             rst,
   input tdw_pkg::tdw_mem_req_s mem_req,
   input wire logic [3:0]       lat,
   output logic                 mem_rvalid,
   output logic [31:0]          mem_rdata,
   output logic                 mem_wdone,
   output int                   bad_wr
);
   logic [31:0] mem [0:4095];
   logic [31:0] ra_q;
   logic [3:0]  cnt_q;
   logic        pend_q;

   // one read in flight; idle data toggles so a stale word never passes
   // word access, engine may write flags only
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_rvalid <= 1'b0;
         mem_wdone <= 1'b0;
         mem_rdata <= 32'h0;
         pend_q <= 1'b0;
         cnt_q <= 4'h0;
         ra_q <= 32'h0;
         bad_wr <= 0;
      end
      else
      begin
         mem_rvalid <= 1'b0;
         mem_wdone <= mem_req.wr;
         mem_rdata <= ~mem_rdata;
         if (mem_req.rd)
         begin
            pend_q <= 1'b1;
            cnt_q <= lat;
            ra_q <= mem_req.addr;
         end
         else if (pend_q && cnt_q <= 4'h1)
         begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[ra_q[13:2]];
            pend_q <= 1'b0;
         end
         else if (pend_q)
            cnt_q <= cnt_q - 4'h1;
         if (mem_req.wr)
         begin
            mem[mem_req.addr[13:2]] <= mem_req.wdata;
            if (mem_req.addr[3:0] != 4'hc)
               bad_wr <= bad_wr + 1;
         end
      end
   end
endmodule : tdw_host_mem

/* File: test/tdw_walker_props.sv */
// Purpose: port timing checks for the descriptor walker
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   the memory partner answers a read within ten cycles
`timescale 1ns/1ns
module tdw_walker_props
(
   input wire logic                    core_clk,
   input wire logic                    rst,
   input wire logic [7:0]              reg_addr,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [31:0]             reg_rdata,
   input tdw_pkg::tdw_mem_req_s        mem_req,
   input wire logic                    mem_rvalid,
   input wire logic                    mem_wdone,
   input tdw_pkg::tdw_frag_s           frag,
   input wire logic                    frag_valid,
   input wire logic                    frag_ready,
   input wire logic [tdw_pkg::NCH-1:0] irq_raw
);
   logic req_any;
   logic open_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // any memory request, read or write
   assign req_any = mem_req.rd | mem_req.wr;

   // a read stays open from its request until its answer
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         open_q <= 1'b0;
      else if (mem_req.rd)
         open_q <= 1'b1;
      else if (mem_rvalid)
         open_q <= 1'b0;
   end

   // a read request and its bounded answer
   sequence s_rd_req;
      mem_req.rd;
   endsequence
   sequence s_rd_ans;
      ##[1:10] mem_rvalid;
   endsequence

   chk_rdata_quiet : assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   chk_unmapped_zero : assert property (reg_rd && reg_addr == 8'h4c |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_rd_pulse : assert property (s_rd_req |=> !mem_req.rd)
      else $error("read request longer than one cycle");
   chk_req_single : assert property (open_q && !mem_rvalid |-> !req_any)
      else $error("second request while a read is open");
   chk_rd_answered : assert property (s_rd_req |-> s_rd_ans)
      else $error("read left without answer");
   chk_frag_hold : assert property (frag_valid && !frag_ready |=> frag_valid && $stable(frag))
      else $error("fragment changed before acceptance");
   chk_addr_aligned : assert property (req_any |-> mem_req.addr[1:0] == 2'b00)
      else $error("memory address not word aligned");
   chk_reset_quiet : assert property ($fell(rst) |-> !frag_valid && irq_raw == '0 && !req_any)
      else $error("outputs busy right after reset");
   // a channel event only follows a finished descriptor write
   chk_irq_cause : assert property ((|(irq_raw & ~$past(irq_raw))) |->
      ($past(mem_wdone) || $past(mem_wdone, 2) || $past(mem_wdone, 3)))
      else $error("completion event without writeback");
   // the event stands until software writes an acknowledge
   chk_irq_stands : assert property ((|(~irq_raw & $past(irq_raw))) |->
      ($past(reg_wr) || $past(reg_wr, 2)))
      else $error("completion event dropped without acknowledge");
endmodule : tdw_walker_props
